// File: logic/tlic_top.sv
// two-level interrupt controller: register file, sampling,
// arbitration, forced call and in-service tracking
// assumes peripherals hold their flags and the core pulses
// MACHINE_CYCLE, INT_ACK and RETURN_FROM_HANDLER_INSTR_EXEC on this same clock
//
// Contract
// R1: seven sources, two programmable priority levels
// R2: every source has its own enable
// R3: each source calls its own fixed vector
// R4: only strictly higher level preempts service
// R5: return instruction ends the current service level
// R6: flags count regardless of any enable
// R7: flags sampled once per machine cycle, polled
// R8: enabled pending sample forces call next cycle
// R9: same level: fixed source order decides
// R10: global mask bit blocks every interrupt
// R11: enable bits 5..0 select six sources
// R12: extension enable bit 1 gates two-wire
// R13: priority bits mirror enable bit positions
// R14: priority one is high, zero low
// R15: serial and timer 2 requests OR flags
// R16: enabled interrupt ends idle mode
// R17: software clears serial done flags itself
// R18: request held until core acknowledges entry
module tlic_top
    import tlic_pkg::*;
(
    input logic CLK,
    input logic RST,
    input logic MACHINE_CYCLE,
    input tlic_pkg::tlic_flags_t FLAGS,
    input tlic_pkg::tlic_sfr_req_t SFR,
    output logic [7:0] SFR_RDATA,
    output logic SFR_HIT,
    output logic INT_REQ,
    output logic [15:0] INT_VECTOR,
    input logic INT_ACK,
    input logic RETURN_FROM_HANDLER_INSTR_EXEC,
    output logic IDLE_CLEAR,
    output logic [1:0] IN_SERVICE
);
    import tlic_pkg::*;

    // ************************************************************
    // register file
    // ************************************************************
    logic [7:0] en_reg; // interrupt_enable
    logic [7:0] en_ext_reg; // interrupt_enable_ext
    logic [7:0] prio_reg; // interrupt_priority
    logic [7:0] prio_ext_reg; // interrupt_priority_ext

    // address decode
    logic hit_en;
    logic hit_en_ext;
    logic hit_prio;
    logic hit_prio_ext;
    logic hit_any;
    assign hit_en = SFR.addr == ADDR_EN;
    assign hit_en_ext = SFR.addr == ADDR_EN_EXT;
    assign hit_prio = SFR.addr == ADDR_PRIO;
    assign hit_prio_ext = SFR.addr == ADDR_PRIO_EXT;
    assign hit_any = hit_en | hit_en_ext | hit_prio | hit_prio_ext;

    // unimplemented bits never store, so they read back zero
    logic [7:0] en_next;
    logic [7:0] en_ext_next;
    logic [7:0] prio_next;
    logic [7:0] prio_ext_next;
    assign en_next = (SFR.wr && hit_en) ? (SFR.wdata & MASK_EN)
                                        : en_reg;
    assign en_ext_next = (SFR.wr && hit_en_ext)
                       ? (SFR.wdata & MASK_EXT) : en_ext_reg;
    assign prio_next = (SFR.wr && hit_prio) ? (SFR.wdata & MASK_MAIN)
                                            : prio_reg;
    assign prio_ext_next = (SFR.wr && hit_prio_ext)
                         ? (SFR.wdata & MASK_EXT) : prio_ext_reg;

    // register writes
    always_ff @(posedge CLK) begin
        if (RST) begin
            en_reg <= RESET_VAL;
            en_ext_reg <= RESET_VAL;
            prio_reg <= RESET_VAL;
            prio_ext_reg <= RESET_VAL;
        end else begin
            en_reg <= en_next; // see R11
            en_ext_reg <= en_ext_next; // see R12
            prio_reg <= prio_next; // see R13
            prio_ext_reg <= prio_ext_next; // see R13
        end
    end

    // read mux
    logic [7:0] rd_mux;
    assign rd_mux = hit_en ? en_reg
                  : hit_en_ext ? en_ext_reg
                  : hit_prio ? prio_reg
                  : hit_prio_ext ? prio_ext_reg
                  : 8'h00;

    // read data answers one cycle after the strobe
    logic [7:0] rdata_reg;
    logic [7:0] rdata_next;
    logic rhit_reg;
    logic rhit_next;
    assign rdata_next = SFR.rd ? rd_mux : 8'h00;
    assign rhit_next = SFR.rd & hit_any;
    always_ff @(posedge CLK) begin
        if (RST) begin
            rdata_reg <= 8'h00;
            rhit_reg <= 1'b0;
        end else begin
            rdata_reg <= rdata_next;
            rhit_reg <= rhit_next;
        end
    end
    assign SFR_RDATA = rdata_reg;
    assign SFR_HIT = rhit_reg;

    // ************************************************************
    // per-source view of the registers
    // ************************************************************
    logic global_mask_bit;
    logic [N_SRC-1:0] src_enable; // index order = vector order
    logic [N_SRC-1:0] src_level; // one = high level
    assign global_mask_bit = en_reg[BIT_GLOBAL];
    assign src_enable = {en_ext_reg[BIT_TWO_WIRE], en_reg[5:0]}; // see R2
    assign src_level = {prio_ext_reg[BIT_TWO_WIRE], prio_reg[5:0]}; // see R14

    // ************************************************************
    // request sampling
    // ************************************************************
    // raw requests; flags are taken whatever the enables say
    logic [N_SRC-1:0] raw_req;
    assign raw_req = {
        FLAGS.two_wire_flag,
        FLAGS.timer2_overflow_flag
            | FLAGS.timer2_external_reload_flag, // see R15
        FLAGS.serial_receive_done_flag
            | FLAGS.serial_transmit_done_flag, // see R15
        FLAGS.timer1_overflow_flag,
        FLAGS.ext1_request_flag,
        FLAGS.timer0_overflow_flag,
        FLAGS.ext0_request_flag
    }; // see R1 R6

    // the serial flags are never cleared here: the handler must
    // clear them or the request keeps coming back, see R17
    logic [N_SRC-1:0] sample_reg;
    logic [N_SRC-1:0] sample_next;
    logic poll_reg; // poll follows MACHINE_CYCLE by one cycle, on the same edge as the sample
    assign sample_next = MACHINE_CYCLE ? raw_req : sample_reg; // see R7

    always_ff @(posedge CLK) begin
        if (RST) begin
            sample_reg <= '0;
            poll_reg <= 1'b0;
        end else begin
            sample_reg <= sample_next;
            poll_reg <= MACHINE_CYCLE; // see R7
        end
    end

    // enabled pending requests
    logic [N_SRC-1:0] pending;
    assign pending = sample_reg & src_enable
                   & {N_SRC{global_mask_bit}}; // see R10

    // ************************************************************
    // arbitration
    // ************************************************************
    logic win_valid;
    logic win_high;
    logic [IDX_W-1:0] win_idx;
    tlic_arbiter #(
        .N(N_SRC)
    ) u_arb (
        .pending(pending),
        .level(src_level),
        .valid(win_valid),
        .high(win_high),
        .idx(win_idx)
    );

    // in-service levels
    logic isr_hi_reg;
    logic isr_lo_reg;
    logic isr_hi_next;
    logic isr_lo_next;

    // a request only beats a strictly lower running level
    logic allowed;
    assign allowed = win_valid && !isr_hi_reg
                   && (win_high || !isr_lo_reg); // see R4

    // ************************************************************
    // call presentation
    // ************************************************************
    tlic_state_t state_reg;
    tlic_state_t state_next;
    logic take;
    logic entry;
    assign take = (state_reg == ST_WAIT) && poll_reg && allowed; // see R8
    assign entry = (state_reg == ST_REQ) && INT_ACK; // see R18

    // next state
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            ST_WAIT: begin
                if (take) begin
                    state_next = ST_REQ;
                end
            end
            ST_REQ: begin
                // the winner stays frozen until the core enters
                if (entry) begin
                    state_next = ST_WAIT; // see R18
                end
            end
            default: begin
                state_next = ST_WAIT;
            end
        endcase
    end

    logic req_reg;
    logic req_next;
    logic [15:0] vec_reg;
    logic [15:0] vec_next;
    logic lvl_reg; // level of the presented call
    logic lvl_next;
    assign req_next = take ? 1'b1 : (entry ? 1'b0 : req_reg);
    assign vec_next = take ? tlic_vector(win_idx) : vec_reg; // see R3
    assign lvl_next = take ? win_high : lvl_reg;

    always_ff @(posedge CLK) begin
        if (RST) begin
            state_reg <= ST_WAIT;
            req_reg <= 1'b0;
            vec_reg <= 16'h0000;
            lvl_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            req_reg <= req_next; // see R8
            vec_reg <= vec_next;
            lvl_reg <= lvl_next;
        end
    end
    assign INT_REQ = req_reg;
    assign INT_VECTOR = vec_reg;

    // ************************************************************
    // in-service tracking
    // ************************************************************
    // return clears the top active level first; an entry in the
    // same cycle then records its own level, so neither is lost
    logic hi_cleared;
    logic lo_cleared;
    assign hi_cleared = isr_hi_reg && !RETURN_FROM_HANDLER_INSTR_EXEC; // see R5
    assign lo_cleared = isr_lo_reg
                      && !(RETURN_FROM_HANDLER_INSTR_EXEC && !isr_hi_reg); // see R5
    assign isr_hi_next = hi_cleared | (entry & lvl_reg); // see R18
    assign isr_lo_next = lo_cleared | (entry & ~lvl_reg); // see R18

    always_ff @(posedge CLK) begin
        if (RST) begin
            isr_hi_reg <= 1'b0;
            isr_lo_reg <= 1'b0;
        end else begin
            isr_hi_reg <= isr_hi_next;
            isr_lo_reg <= isr_lo_next;
        end
    end
    assign IN_SERVICE = {isr_hi_reg, isr_lo_reg};

    // ************************************************************
    // idle wake-up
    // ************************************************************
    // any enabled request wakes the core, even one that cannot
    // preempt yet; the core then waits at its own level
    logic wake_reg;
    logic wake_next;
    assign wake_next = poll_reg && (|pending); // see R16
    always_ff @(posedge CLK) begin
        if (RST) begin
            wake_reg <= 1'b0;
        end else begin
            wake_reg <= wake_next;
        end
    end
    assign IDLE_CLEAR = wake_reg;

    // ************************************************************
    // checks
    // ************************************************************
    default clocking cb @(posedge CLK); endclocking
    default disable iff (RST);

    property p_vector;
        take |=> INT_REQ && INT_VECTOR == tlic_vector($past(win_idx));
    endproperty
    a_vector: assert property (p_vector) else $error("bad vector"); // see R3

    property p_hold;
        INT_REQ && !INT_ACK |=> INT_REQ && $stable(INT_VECTOR);
    endproperty
    a_hold: assert property (p_hold) else $error("call dropped"); // see R18

    property p_mask;
        poll_reg && !global_mask_bit && !INT_REQ |=> !INT_REQ;
    endproperty
    a_mask: assert property (p_mask) else $error("masked call"); // see R10

    property p_preempt_hi;
        isr_hi_reg && !INT_REQ |=> !INT_REQ;
    endproperty
    a_preempt_hi: assert property (p_preempt_hi)
        else $error("preempted high"); // see R4

    property p_preempt_lo;
        isr_lo_reg && !win_high && !INT_REQ |=> !INT_REQ;
    endproperty
    a_preempt_lo: assert property (p_preempt_lo)
        else $error("equal level preempted"); // see R4

    property p_return;
        RETURN_FROM_HANDLER_INSTR_EXEC && isr_hi_reg && !entry |=> !isr_hi_reg;
    endproperty
    a_return: assert property (p_return) else $error("return lost"); // see R5

    property p_sample;
        !MACHINE_CYCLE |=> $stable(sample_reg);
    endproperty
    a_sample: assert property (p_sample) else $error("extra sample"); // see R7

    property p_wake;
        MACHINE_CYCLE ##1 (|pending) |=> IDLE_CLEAR;
    endproperty
    a_wake: assert property (p_wake) else $error("no wake"); // see R16

    property p_entry;
        INT_REQ && INT_ACK |=> (lvl_reg ? isr_hi_reg : isr_lo_reg)
            && !INT_REQ;
    endproperty
    a_entry: assert property (p_entry) else $error("entry lost"); // see R18

    // the arbiter has no clock of its own, so its choice is watched here
    property p_order;
        win_valid |-> pending[win_idx] && src_level[win_idx] == win_high
            && (win_high || (pending & src_level) == '0)
            && (pending & (src_level ^ {N_SRC{!win_high}})
                & ((N_SRC'(1) << win_idx) - N_SRC'(1))) == '0;
    endproperty
    a_order: assert property (p_order) else $error("tie order"); // see R9

endmodule // tlic_top

// File: pkg/tlic_pkg.sv
// shared constants and types of the two-level interrupt controller
// assumes one system clock and the core's special-function register port
package tlic_pkg;

    // ************************************************************
    // sources and register map
    // ************************************************************
    localparam int N_SRC = 7; // request sources
    localparam int IDX_W = 3; // width of a source index
    localparam logic [7:0] ADDR_EN = 8'hA8; // interrupt_enable
    localparam logic [7:0] ADDR_EN_EXT = 8'hA9; // interrupt_enable_ext
    localparam logic [7:0] ADDR_PRIO = 8'hB8; // interrupt_priority
    localparam logic [7:0] ADDR_PRIO_EXT = 8'hB9; // interrupt_priority_ext
    localparam logic [7:0] RESET_VAL = 8'h00; // all four registers
    localparam int BIT_GLOBAL = 7; // global_mask_bit position
    localparam int BIT_TWO_WIRE = 1; // two-wire bit in the ext registers
    localparam logic [7:0] MASK_MAIN = 8'h3F; // implemented per-source bits
    localparam logic [7:0] MASK_EN = 8'hBF; // enable adds the global bit
    localparam logic [7:0] MASK_EXT = 8'h02; // only bit 1 exists

    // ************************************************************
    // vectors, fixed order is also the tie-break order
    // ************************************************************
    localparam logic [15:0] VEC_EXT0 = 16'h0003;
    localparam logic [15:0] VEC_TIMER0 = 16'h000B;
    localparam logic [15:0] VEC_EXT1 = 16'h0013;
    localparam logic [15:0] VEC_TIMER1 = 16'h001B;
    localparam logic [15:0] VEC_SERIAL = 16'h0023;
    localparam logic [15:0] VEC_TIMER2 = 16'h002B;
    localparam logic [15:0] VEC_TWO_WIRE = 16'h003B;

    // source index to call target
    function automatic logic [15:0] tlic_vector(input logic [IDX_W-1:0] i);
        case (i)
            3'h0: tlic_vector = VEC_EXT0;
            3'h1: tlic_vector = VEC_TIMER0;
            3'h2: tlic_vector = VEC_EXT1;
            3'h3: tlic_vector = VEC_TIMER1;
            3'h4: tlic_vector = VEC_SERIAL;
            3'h5: tlic_vector = VEC_TIMER2;
            default: tlic_vector = VEC_TWO_WIRE;
        endcase
    endfunction

    // ************************************************************
    // carriers and states
    // ************************************************************
    typedef struct packed {
        logic ext0_request_flag;
        logic timer0_overflow_flag;
        logic ext1_request_flag;
        logic timer1_overflow_flag;
        logic serial_receive_done_flag;
        logic serial_transmit_done_flag;
        logic timer2_overflow_flag;
        logic timer2_external_reload_flag;
        logic two_wire_flag;
    } tlic_flags_t;

    typedef struct packed {
        logic wr; // one-cycle write strobe
        logic rd; // one-cycle read strobe
        logic [7:0] addr; // register address
        logic [7:0] wdata; // write data
    } tlic_sfr_req_t;

    typedef enum logic [1:0] {
        ST_WAIT = 2'b01, // polling, nothing presented
        ST_REQ = 2'b10 // call presented, waiting for entry
    } tlic_state_t;

endpackage

// File: logic/tlic_arbiter.sv
// fixed-order two-level winner selection
// assumes pending is already gated by all enables
module tlic_arbiter
    import tlic_pkg::*;
#(
    parameter int N = N_SRC
) (
    input logic [N-1:0] pending,
    input logic [N-1:0] level,
    output logic valid,
    output logic high,
    output logic [IDX_W-1:0] idx
);
    // refuse a source count that the index cannot name
    if (N < 1 || N > (1 << IDX_W)) begin : g_bad_n
        $error("tlic_arbiter: bad N");
    end

    logic [N-1:0] cand_hi; // pending in the high level
    logic [N-1:0] cand; // the level that competes
    logic [N-1:0] seen; // a lower index already won
    logic [N-1:0] onehot; // single winner
    assign cand_hi = pending & level;
    assign high = |cand_hi; // high level beats low, see R14
    assign cand = high ? cand_hi : pending;
    assign valid = |pending;

    // ************************************************************
    // lowest index wins inside a level
    // ************************************************************
    genvar g;
    generate
        for (g = 0; g < N; g++) begin : g_pick
            if (g == 0) begin : g_first
                assign seen[g] = 1'b0;
            end else begin : g_rest
                assign seen[g] = seen[g-1] | cand[g-1];
            end
            assign onehot[g] = cand[g] & ~seen[g]; // see R9
        end
    endgenerate

    // index of the one-hot winner
    always_comb begin
        idx = '0;
        for (int k = 0; k < N; k++) begin
            if (onehot[k]) begin
                idx = IDX_W'(k);
            end
        end
    end

endmodule // tlic_arbiter

// File: testbench/tlic_core_model.sv
// core-side stand-in: enters handlers on call and executes returns
// assumes the bench drives the peripheral flags and asks for returns
// through ret_go, both on the falling edge
module tlic_core_model (
    input wire logic clk,
    input wire logic rst,
    input wire logic int_req,
    input wire logic slow,
    input wire logic ret_go,
    output logic int_ack,
    output logic return_from_handler_instr_exec
);
    timeunit 1ns;
    timeprecision 1ns;

    // ************************************************************
    // handler entry and return
    // ************************************************************
    int wait_cnt; // cycles the presented call has waited

    initial begin
        int_ack = 1'b0;
        return_from_handler_instr_exec = 1'b0;
        wait_cnt = 0;
    end

    // entry comes at once or three cycles late; one pulse per call,
    // because a held call must not be entered twice
    always @(negedge clk) begin
        if (rst || !int_req || int_ack) begin
            int_ack <= 1'b0;
            wait_cnt <= 0;
        end else if (wait_cnt >= (slow ? 3 : 0)) begin
            int_ack <= 1'b1;
        end else begin
            wait_cnt <= wait_cnt + 1;
        end
        // a return is one instruction, so one cycle
        return_from_handler_instr_exec <= ret_go && !rst;
    end
endmodule // tlic_core_model

// File: testbench/tlic_top_bench.sv
// self-checking bench of the interrupt controller with a core model
// assumes one 10 MHz clock, inputs moved on the falling edge
module tlic_top_bench;
    timeunit 1ns;
    timeprecision 1ns;
    import tlic_pkg::*;

    // ************************************************************
    // stimulus and observed signals
    // ************************************************************
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic machine_cycle = 1'b0;
    tlic_flags_t flags = '0;
    tlic_sfr_req_t sfr = '0;
    logic [7:0] rdata;
    logic hit;
    logic int_req;
    logic [15:0] vec;
    logic int_ack;
    logic return_from_handler_instr_exec;
    logic idle_clr;
    logic [1:0] in_svc;
    logic slow = 1'b0;
    logic ret_go = 1'b0;
    int error_cnt = 0;
    int tests_run = 0;
    int cycles = 0;
    int seed = 32'hC251E132;

    // ************************************************************
    // reference model state
    // ************************************************************
    logic [7:0] adr [4] = '{ADDR_EN, ADDR_EN_EXT, ADDR_PRIO, ADDR_PRIO_EXT};
    logic [7:0] msk [4] = '{8'hBF, 8'h02, 8'h3F, 8'h02};
    logic [7:0] rm [4] = '{8'h00, 8'h00, 8'h00, 8'h00};
    logic [15:0] vec_tab [7] = '{16'h0003, 16'h000B, 16'h0013,
        16'h001B, 16'h0023, 16'h002B, 16'h003B};
    logic [6:0] pend = '0; // sources whose flag is up
    logic hi_m = 1'b0; // high level in service
    logic lo_m = 1'b0; // low level in service

    tlic_top u_tlic_top (.CLK(clk), .RST(rst),
        .MACHINE_CYCLE(machine_cycle), .FLAGS(flags), .SFR(sfr),
        .SFR_RDATA(rdata), .SFR_HIT(hit), .INT_REQ(int_req),
        .INT_VECTOR(vec), .INT_ACK(int_ack), .RETURN_FROM_HANDLER_INSTR_EXEC(return_from_handler_instr_exec),
        .IDLE_CLEAR(idle_clr), .IN_SERVICE(in_svc));
    tlic_core_model u_tlic_core_model (.clk(clk), .rst(rst),
        .int_req(int_req), .slow(slow), .ret_go(ret_go),
        .int_ack(int_ack), .return_from_handler_instr_exec(return_from_handler_instr_exec));

    initial begin
        forever #50 clk = ~clk;
    end

    // a hung handshake must still reach the verdict
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            error_cnt++;
            tally_and_finish();
        end
    end

    // ************************************************************
    // helpers
    // ************************************************************
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [15:0] exp,
            input logic [15:0] got);
        tests_run++;
        if (got !== exp) begin
            $display("unexpected %s: expected %h seen %h", what, exp, got);
            error_cnt++;
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(negedge clk);
    endtask

    // index of a mapped register, -1 when unmapped
    function automatic int find(input logic [7:0] a);
        for (int k = 0; k < 4; k++) begin
            if (adr[k] == a) return k;
        end
        return -1;
    endfunction

    task automatic sfr_wr(input logic [7:0] a, input logic [7:0] d);
        int k;
        k = find(a);
        sfr = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        tick(1);
        sfr.wr = 1'b0;
        tick(1);
        // unused bits store zero, unmapped writes vanish
        if (k >= 0) rm[k] = d & msk[k];
    endtask

    task automatic sfr_rd(input logic [7:0] a);
        int k;
        logic [7:0] ex;
        k = find(a);
        ex = (k < 0) ? 8'h00 : rm[k];
        sfr = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        tick(1);
        sfr.rd = 1'b0;
        chk("read data", {8'h00, ex}, {8'h00, rdata});
        chk("read hit", {15'h0000, k >= 0}, {15'h0000, hit});
        tick(1);
    endtask

    task automatic set_regs(input logic [7:0] e, ex, p, px);
        sfr_wr(ADDR_EN, e);
        sfr_wr(ADDR_EN_EXT, ex);
        sfr_wr(ADDR_PRIO, p);
        sfr_wr(ADDR_PRIO_EXT, px);
    endtask

    // alt picks the second flag of the two-flag sources
    task automatic set_src(input logic [6:0] s, input logic alt);
        flags = '0;
        flags.ext0_request_flag = s[0];
        flags.timer0_overflow_flag = s[1];
        flags.ext1_request_flag = s[2];
        flags.timer1_overflow_flag = s[3];
        flags.serial_receive_done_flag = s[4] && !alt;
        flags.serial_transmit_done_flag = s[4] && alt;
        flags.timer2_overflow_flag = s[5] && !alt;
        flags.timer2_external_reload_flag = s[5] && alt;
        flags.two_wire_flag = s[6];
        pend = s;
    endtask

    // winner by level then fixed order, -1 when nothing may be taken
    function automatic int win(input logic [6:0] p);
        int best;
        int bl;
        logic [6:0] en7;
        logic [6:0] lv7;
        best = -1;
        bl = -1;
        en7 = {rm[1][1], rm[0][5:0]};
        lv7 = {rm[3][1], rm[2][5:0]};
        if (!rm[0][7] || hi_m) return -1;
        for (int i = 0; i < 7; i++) begin
            if (p[i] && en7[i] && int'(lv7[i]) > bl) begin
                best = i;
                bl = int'(lv7[i]);
            end
        end
        if (lo_m && bl < 1) return -1;
        return best;
    endfunction

    // one machine-cycle sample, then the call and its entry
    task automatic sample();
        int w;
        logic idle_exp;
        logic lv;
        w = win(pend);
        idle_exp = rm[0][7] && |(pend & {rm[1][1], rm[0][5:0]});
        lv = (w == 6) ? rm[3][1] : rm[2][w % 6];
        machine_cycle = 1'b1;
        tick(1);
        machine_cycle = 1'b0;
        // call and wake pulse both stand in the cycle after the poll
        tick(1);
        chk("idle wake", {15'h0, idle_exp}, {15'h0, idle_clr});
        chk("call", {15'h0000, w >= 0}, {15'h0000, int_req});
        if (w >= 0) begin
            chk("vector", vec_tab[w], vec);
            repeat (10) if (int_req === 1'b1) tick(1);
            chk("call drop", 16'h0000, {15'h0000, int_req});
            if (lv) hi_m = 1'b1;
            else lo_m = 1'b1;
            chk("in service", {14'h0, hi_m, lo_m}, {14'h0, in_svc});
        end
    endtask

    task automatic ret();
        ret_go <= 1'b1;
        tick(1);
        ret_go <= 1'b0;
        tick(2);
        if (hi_m) hi_m = 1'b0;
        else lo_m = 1'b0;
        chk("in service", {14'h0, hi_m, lo_m}, {14'h0, in_svc});
    endtask

    // software drops every flag, serial done flags included
    task automatic clean();
        set_src(7'h00, 1'b0);
        sample();
        ret();
        ret();
    endtask

    // ************************************************************
    // scenarios
    // ************************************************************
    initial begin
        tick(4);
        rst = 1'b0;
        for (int k = 0; k < 4; k++) sfr_rd(adr[k]);
        sfr_rd(8'hAA);
        for (int k = 0; k < 5; k++) begin
            sfr_wr(k < 4 ? adr[k] : 8'hB0, 8'($random(seed)));
            sfr_rd(k < 4 ? adr[k] : 8'hB0);
        end
        // every source alone, both flags of the shared sources
        for (int s = 0; s < 7; s++) begin
            for (int alt = 0; alt < 2; alt++) begin
                set_regs(s < 6 ? 8'h80 | 8'(1 << s) : 8'h80,
                    s == 6 ? 8'h02 : 8'h00, 8'($random(seed)),
                    8'($random(seed)));
                slow <= alt[0];
                set_src(7'(1 << s), alt[0]);
                sample();
                clean();
            end
        end
        // global bit clear blocks all sources
        set_regs(8'h3F, 8'h02, 8'h00, 8'h00);
        set_src(7'h7F, 1'b0);
        sample();
        clean();
        // flags up while disabled still count once enabled
        set_regs(8'h80, 8'h00, 8'h00, 8'h00);
        set_src(7'h7F, 1'b1);
        sample();
        sfr_wr(ADDR_EN, 8'h88);
        sample();
        clean();
        // no machine cycle, no sample, no call
        set_regs(8'hBF, 8'h02, 8'h00, 8'h00);
        set_src(7'h7F, 1'b0);
        tick(4);
        chk("unsampled", 16'h0000, {15'h0000, int_req});
        sample();
        sample();
        sfr_wr(ADDR_PRIO, 8'h04);
        sample();
        sample();
        ret();
        clean();
        // random mixes of enables, levels and flags
        repeat (12) begin
            set_regs(8'($random(seed)) | 8'h80, 8'($random(seed)),
                8'($random(seed)), 8'($random(seed)));
            set_src(7'($random(seed)), 1'($random(seed)));
            sample();
            sample();
            clean();
        end
        tally_and_finish();
    end
endmodule // tlic_top_bench
